// [design/lfcs_cfg.svh]
// Offsets, bit positions, reset values and timing counts of the LIN
// frame control and status block.
// Assumes a 100 MHz REF_CLK; included by bare name.
`ifndef LFCS_CFG_SVH
`define LFCS_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LFCS_OFS_CTRL 8'h08
`define LFCS_OFS_STAT 8'h09
`define LFCS_OFS_ERR 8'h0A
`define LFCS_OFS_SIZE 8'h0B
`define LFCS_OFS_CFG 8'h0F

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LFCS_CTRL_STOP 7
`define LFCS_CTRL_SLEEP 6
`define LFCS_CTRL_DIR 5
`define LFCS_CTRL_ACK 4
`define LFCS_CTRL_IRQCLR 3
`define LFCS_CTRL_ERRCLR 2
`define LFCS_CTRL_WAKE 1
`define LFCS_CTRL_START 0
`define LFCS_ST_ACTIVE 7
`define LFCS_ST_IDLE 6
`define LFCS_ST_ABORT 5
`define LFCS_ST_IDRX 4
`define LFCS_ST_IRQ 3
`define LFCS_ST_ERROR 2
`define LFCS_ST_WAKEUP 1
`define LFCS_ST_DONE 0
`define LFCS_ERR_SYNC 4
`define LFCS_ERR_PAR 3
`define LFCS_ERR_FRAME_TIMEOUT_ERROR 2
`define LFCS_ERR_CHK 1
`define LFCS_ERR_BIT 0
`define LFCS_SIZE_ENH 7
`define LFCS_CFG_MODE 6

// ------------------------------------------------------------
// Reset values and length codes
// ------------------------------------------------------------
`define LFCS_RST_BYTE 8'h00
`define LFCS_LEN_MAX 4'h8
`define LFCS_LEN_BY_ID 4'hF

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LFCS_CLK_HZ 100000000
`define LFCS_IDLE_TIME_S 4
`define LFCS_IDLE_CYC (`LFCS_IDLE_TIME_S * `LFCS_CLK_HZ)
`define LFCS_WAKE_TIME_US 250
`define LFCS_WAKE_CYC (`LFCS_WAKE_TIME_US * (`LFCS_CLK_HZ / 1000000))
`define LFCS_FRAME_TIME_US 10000
`define LFCS_FRAME_CYC (`LFCS_FRAME_TIME_US * (`LFCS_CLK_HZ / 1000000))

`endif

// [design/lfcs_pkg.sv]
// Types for the LIN frame control block: link states and the register byte.
// Assumes nothing beyond a SystemVerilog compiler.
package lfcs_pkg;
   typedef enum logic [1:0] {
      LFCS_IDLE = 2'b00,
      LFCS_FRAME = 2'b01,
      LFCS_WAKE = 2'b10
   } lfcs_state_e;
   typedef logic [7:0] lfcs_byte_t;
endpackage : lfcs_pkg

// [design/lfcs_if.sv]
// Link between the control/status block and the LIN frame engine.
// Both ends run on the same REF_CLK; pulses are one cycle long.
`timescale 1ns/1ps
interface lfcs_if;
   logic start_p;
   logic stop_p;
   logic ack_p;
   logic wake_p;
   logic dir;
   logic master;
   logic [3:0] len;
   logic enh;
   logic active;
   logic brk_p;
   logic id_p;
   logic byte1_p;
   logic done_p;
   logic [4:0] err_p;
   logic wake_rx_p;
   logic wake_tx;
   logic [1:0] id_hi;

   modport ctrl (output start_p, stop_p, ack_p, wake_p, dir, master, len, enh,
                 input active, brk_p, id_p, byte1_p, done_p, err_p, wake_rx_p, wake_tx, id_hi);
   modport link (input start_p, stop_p, ack_p, wake_p, dir, master, len, enh,
                 output active, brk_p, id_p, byte1_p, done_p, err_p, wake_rx_p, wake_tx, id_hi);
endinterface : lfcs_if

// [design/lfcs_link.sv]
// LIN frame engine end: turns bus-side events into link pulses and
// carries frame, wake-up and timeout timing.
// Assumes BUS_RX is an asynchronous pin; all EV_ inputs are on REF_CLK.
`timescale 1ns/1ps
`include "lfcs_cfg.svh"
module lfcs_link #(
   parameter int FRAME_CYC = `LFCS_FRAME_CYC,
   parameter int WAKE_CYC = `LFCS_WAKE_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   lfcs_if.link LNK,
   input wire logic BUS_RX,
   input wire logic EV_BREAK,
   input wire logic EV_ID,
   input wire logic EV_BYTE1,
   input wire logic EV_DONE,
   input wire logic EV_SYNC_ERR,
   input wire logic EV_PAR_ERR,
   input wire logic EV_CHK_ERR,
   input wire logic EV_BIT_ERR,
   input wire logic EV_WAKE_RX,
   input wire logic [1:0] ID_HI,
   output logic TX_START,
   output logic TX_DIR,
   output logic [3:0] TX_LEN,
   output logic TX_ENH,
   output logic WAKE_DRV
);
   logic rx_s1_r, rx_s2_r;
   lfcs_pkg::lfcs_state_e state_r;
   logic [31:0] cnt_r;
   logic frame_timeout_error;

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= BUS_RX;
         rx_s2_r <= rx_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Frame and wake sequencing
   // ------------------------------------------------------------
   // Frame timer covers both a silent slave and an over-long frame
   assign frame_timeout_error = (state_r == lfcs_pkg::LFCS_FRAME) && (cnt_r >= 32'(FRAME_CYC - 1)) && !EV_DONE;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_r <= lfcs_pkg::LFCS_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            lfcs_pkg::LFCS_IDLE: begin
               cnt_r <= '0;
               if (LNK.wake_p) begin
                  state_r <= lfcs_pkg::LFCS_WAKE;
               end else if (LNK.start_p || EV_BREAK) begin
                  state_r <= lfcs_pkg::LFCS_FRAME;
               end
            end
            lfcs_pkg::LFCS_FRAME: begin
               cnt_r <= cnt_r + 32'd1;
               if (EV_BREAK) begin
                  cnt_r <= '0;
               end else if (EV_DONE || frame_timeout_error || LNK.stop_p || EV_BIT_ERR) begin
                  state_r <= lfcs_pkg::LFCS_IDLE;
               end
            end
            lfcs_pkg::LFCS_WAKE: begin
               cnt_r <= cnt_r + 32'd1;
               if (cnt_r >= 32'(WAKE_CYC - 1)) begin
                  state_r <= lfcs_pkg::LFCS_IDLE;
               end
            end
            default: begin
               state_r <= lfcs_pkg::LFCS_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Link pulses and levels back to the control block
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         LNK.active <= 1'b0;
         LNK.brk_p <= 1'b0;
         LNK.id_p <= 1'b0;
         LNK.byte1_p <= 1'b0;
         LNK.done_p <= 1'b0;
         LNK.err_p <= '0;
         LNK.wake_rx_p <= 1'b0;
         LNK.wake_tx <= 1'b0;
         LNK.id_hi <= '0;
      end else begin
         LNK.active <= !rx_s2_r || (state_r == lfcs_pkg::LFCS_FRAME);
         LNK.brk_p <= EV_BREAK;
         LNK.id_p <= EV_ID;
         LNK.byte1_p <= EV_BYTE1;
         LNK.done_p <= EV_DONE && (state_r == lfcs_pkg::LFCS_FRAME);
         LNK.err_p <= {EV_SYNC_ERR, EV_PAR_ERR, frame_timeout_error, EV_CHK_ERR, EV_BIT_ERR};
         LNK.wake_rx_p <= EV_WAKE_RX;
         LNK.wake_tx <= (state_r == lfcs_pkg::LFCS_WAKE);
         LNK.id_hi <= ID_HI;
      end
   end

   // ------------------------------------------------------------
   // User-side outputs
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TX_START <= 1'b0;
         TX_DIR <= 1'b0;
         TX_LEN <= '0;
         TX_ENH <= 1'b0;
         WAKE_DRV <= 1'b0;
      end else begin
         TX_START <= LNK.start_p && (state_r == lfcs_pkg::LFCS_IDLE);
         TX_DIR <= LNK.dir;
         TX_LEN <= LNK.len;
         TX_ENH <= LNK.enh;
         WAKE_DRV <= (state_r == lfcs_pkg::LFCS_WAKE);
      end
   end
endmodule : lfcs_link

// [design/lfcs_ctrl.sv]
// Control, status, error and message-size registers of a LIN
// controller, master or slave, behind an 8-bit indirect register port.
// Assumes the frame engine on the link shares REF_CLK.
//
// Operation
// [RULE_01] Slave stop bit: ignore bus until break
// [RULE_02] Application sets sleep warning, clears on wake
// [RULE_03] Direction bit: 0 receive, 1 transmit
// [RULE_04] Slave data acknowledge, self clearing
// [RULE_05] Interrupt clear strobe clears pending bit
// [RULE_06] Error clear strobe clears all error bits
// [RULE_07] Wake request sends wake-up, then self clears
// [RULE_08] Master start request; cleared on done/error
// [RULE_09] Activity bit follows bus activity
// [RULE_10] Slave idle timeout after four seconds
// [RULE_11] Slave abort on early break or stop
// [RULE_12] Slave identifier received flag
// [RULE_13] Summary error sticky until error clear
// [RULE_14] Wake-up bit: sending or received
// [RULE_15] Done cleared at frame start, set at end
// [RULE_16] Slave sync field error flag
// [RULE_17] Slave parity error flag
// [RULE_18] Timeout error: four causes
// [RULE_19] Checksum mismatch error flag
// [RULE_20] Readback mismatch error flag
// [RULE_21] Checksum variant: classic or enhanced
// [RULE_22] Length codes 0-8, reserved, by-identifier
// [RULE_23] By-identifier lengths 2,2,4,8 bytes
// [RULE_24] Mode bit: 0 slave, 1 master
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "lfcs_cfg.svh"
module lfcs_ctrl #(
   parameter int IDLE_CYC = `LFCS_IDLE_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output lfcs_pkg::lfcs_byte_t REG_RDATA,
   lfcs_if.ctrl LNK
);
   logic master_r, sleep_r, dir_r, ack_r, wreq_r, start_r;
   logic [7:0] size_r;
   logic blocked_r, frame_r, wait_ack_r;
   logic idle_r, abort_r, idrx_r, irq_r, error_r, wake_rx_r, done_r;
   logic [4:0] err_r;
   logic [31:0] idle_cnt_r;
   logic wr_ctrl, wr_size, wr_cfg, irq_clr, err_clr, stop_wr, ack_wr;
   logic ok, brk, id_ev, done_ev, ack_miss, err_any;
   logic [4:0] err_set;
   logic [3:0] len_nxt;

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   assign wr_ctrl = REG_WR && (REG_ADDR == `LFCS_OFS_CTRL);
   assign wr_size = REG_WR && (REG_ADDR == `LFCS_OFS_SIZE);
   assign wr_cfg = REG_WR && (REG_ADDR == `LFCS_OFS_CFG);
   assign irq_clr = wr_ctrl && REG_WDATA[`LFCS_CTRL_IRQCLR]; // [RULE_05]
   assign err_clr = wr_ctrl && REG_WDATA[`LFCS_CTRL_ERRCLR]; // [RULE_06]
   assign stop_wr = wr_ctrl && REG_WDATA[`LFCS_CTRL_STOP] && !master_r; // [RULE_01] [RULE_24]
   assign ack_wr = wr_ctrl && REG_WDATA[`LFCS_CTRL_ACK] && !master_r; // [RULE_04] [RULE_24]

   // ------------------------------------------------------------
   // Event qualification
   // ------------------------------------------------------------
   // While stopped, everything but the next break and a received wake-up is ignored
   assign brk = LNK.brk_p && !master_r;
   assign ok = !blocked_r; // [RULE_01]
   assign id_ev = LNK.id_p && ok && !master_r;
   assign done_ev = LNK.done_p && ok;
   assign ack_miss = LNK.byte1_p && ok && wait_ack_r && !ack_wr && !stop_wr; // [RULE_18]
   always_comb begin
      err_set = LNK.err_p & {5{ok}};
      err_set[`LFCS_ERR_SYNC] = err_set[`LFCS_ERR_SYNC] && !master_r; // [RULE_16]
      err_set[`LFCS_ERR_PAR] = err_set[`LFCS_ERR_PAR] && !master_r; // [RULE_17]
      err_set[`LFCS_ERR_FRAME_TIMEOUT_ERROR] = err_set[`LFCS_ERR_FRAME_TIMEOUT_ERROR] || ack_miss; // [RULE_18]
   end
   assign err_any = |err_set;

   // ------------------------------------------------------------
   // Configuration and message size
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         master_r <= 1'b0;
         size_r <= `LFCS_RST_BYTE;
      end else begin
         if (wr_cfg) begin
            master_r <= REG_WDATA[`LFCS_CFG_MODE]; // [RULE_24]
         end
         if (wr_size) begin
            size_r <= {REG_WDATA[`LFCS_SIZE_ENH], 3'h0, REG_WDATA[3:0]}; // [RULE_21]
         end
      end
   end

   // Reserved codes give no data bytes rather than a guess
   always_comb begin
      if (size_r[3:0] == `LFCS_LEN_BY_ID) begin
         case (LNK.id_hi) // [RULE_23]
            2'h2: len_nxt = 4'h4;
            2'h3: len_nxt = 4'h8;
            default: len_nxt = 4'h2;
         endcase
      end else if (size_r[3:0] > `LFCS_LEN_MAX) begin
         len_nxt = 4'h0; // [RULE_22]
      end else begin
         len_nxt = size_r[3:0]; // [RULE_22]
      end
   end

   // ------------------------------------------------------------
   // Control bits
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sleep_r <= 1'b0;
         dir_r <= 1'b0;
         ack_r <= 1'b0;
         wreq_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            sleep_r <= REG_WDATA[`LFCS_CTRL_SLEEP]; // [RULE_02]
            dir_r <= REG_WDATA[`LFCS_CTRL_DIR]; // [RULE_03]
         end
         ack_r <= ack_wr; // [RULE_04]
         wreq_r <= (wreq_r && !LNK.wake_tx) || (wr_ctrl && REG_WDATA[`LFCS_CTRL_WAKE]); // [RULE_07]
         start_r <= (start_r && !done_ev && !err_any)
                    || (wr_ctrl && REG_WDATA[`LFCS_CTRL_START] && master_r); // [RULE_08]
      end
   end

   // ------------------------------------------------------------
   // Link outputs
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         LNK.start_p <= 1'b0;
         LNK.stop_p <= 1'b0;
         LNK.ack_p <= 1'b0;
         LNK.wake_p <= 1'b0;
         LNK.dir <= 1'b0;
         LNK.master <= 1'b0;
         LNK.len <= '0;
         LNK.enh <= 1'b0;
      end else begin
         // A start written while one runs is not re-sent
         LNK.start_p <= wr_ctrl && REG_WDATA[`LFCS_CTRL_START] && master_r && !start_r; // [RULE_08]
         LNK.stop_p <= stop_wr; // [RULE_01]
         LNK.ack_p <= ack_wr; // [RULE_04]
         LNK.wake_p <= wr_ctrl && REG_WDATA[`LFCS_CTRL_WAKE] && !wreq_r; // [RULE_07]
         LNK.dir <= dir_r; // [RULE_03]
         LNK.master <= master_r;
         LNK.len <= len_nxt;
         LNK.enh <= size_r[`LFCS_SIZE_ENH]; // [RULE_21]
      end
   end

   // ------------------------------------------------------------
   // Frame tracking, stop and acknowledge window
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         blocked_r <= 1'b0;
         frame_r <= 1'b0;
         wait_ack_r <= 1'b0;
      end else begin
         blocked_r <= (blocked_r && !brk) || stop_wr; // [RULE_01]
         frame_r <= (frame_r && !done_ev && !err_any && !stop_wr) || LNK.start_p || brk;
         wait_ack_r <= (wait_ack_r && !ack_wr && !stop_wr && !LNK.byte1_p && !brk) || id_ev;
      end
   end

   // ------------------------------------------------------------
   // Idle timeout
   // ------------------------------------------------------------
   // Counter saturates so the flag cannot wrap back to zero
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         idle_cnt_r <= '0;
         idle_r <= 1'b0;
      end else if (LNK.active || master_r) begin
         idle_cnt_r <= '0;
         idle_r <= 1'b0;
      end else begin
         if (idle_cnt_r < 32'(IDLE_CYC)) begin
            idle_cnt_r <= idle_cnt_r + 32'd1;
         end
         if (idle_cnt_r >= 32'(IDLE_CYC - 1) && !sleep_r) begin
            idle_r <= 1'b1; // [RULE_10]
         end
      end
   end

   // ------------------------------------------------------------
   // Status and error flags: set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         abort_r <= 1'b0;
         idrx_r <= 1'b0;
         done_r <= 1'b0;
         wake_rx_r <= 1'b0;
      end else begin
         if (stop_wr || (brk && frame_r)) begin
            abort_r <= 1'b1; // [RULE_11]
         end else if (brk) begin
            abort_r <= 1'b0; // [RULE_11]
         end
         idrx_r <= (idrx_r && !ack_wr && !stop_wr && !brk) || id_ev; // [RULE_12]
         if (done_ev) begin
            done_r <= 1'b1; // [RULE_15]
         end else if (LNK.start_p || brk) begin
            done_r <= 1'b0; // [RULE_15]
         end
         wake_rx_r <= (wake_rx_r && !brk && !LNK.start_p) || LNK.wake_rx_p; // [RULE_14]
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         err_r <= '0;
         error_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         err_r <= (err_r & ~{5{err_clr}}) | err_set; // [RULE_06] [RULE_16] [RULE_17] [RULE_19] [RULE_20]
         error_r <= (error_r && !err_clr) || err_any; // [RULE_13]
         irq_r <= (irq_r && !irq_clr) || err_any || done_ev || id_ev || LNK.wake_rx_p
                  || (stop_wr || (brk && frame_r))
                  || (!idle_r && idle_cnt_r >= 32'(IDLE_CYC - 1) && !sleep_r && !LNK.active && !master_r); // [RULE_05]
      end
   end

   // ------------------------------------------------------------
   // Read port: data valid only in the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         REG_RDATA <= `LFCS_RST_BYTE;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `LFCS_OFS_CTRL: REG_RDATA <= {1'b0, sleep_r, dir_r, ack_r, 2'h0, wreq_r, start_r}; // [RULE_01]
            `LFCS_OFS_STAT: REG_RDATA <= {LNK.active, idle_r, abort_r, idrx_r, irq_r, error_r,
                                          LNK.wake_tx || wake_rx_r, done_r}; // [RULE_09] [RULE_14]
            `LFCS_OFS_ERR: REG_RDATA <= {3'h0, err_r};
            `LFCS_OFS_SIZE: REG_RDATA <= size_r;
            `LFCS_OFS_CFG: REG_RDATA <= {1'b0, master_r, 6'h00};
            default: REG_RDATA <= `LFCS_RST_BYTE;
         endcase
      end else begin
         REG_RDATA <= `LFCS_RST_BYTE;
      end
   end
endmodule : lfcs_ctrl

// [bench/lfcs_props.sv]
// Concurrent checks on the link between lfcs_ctrl and lfcs_link.
// Assumes one REF_CLK for both ends and RST synchronous, active high.
`timescale 1ns/1ps
module lfcs_props #(
   parameter int WAKE_CYC = 20
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic start_p,
   input wire logic stop_p,
   input wire logic ack_p,
   input wire logic wake_p,
   input wire logic master,
   input wire logic wake_tx
);
   // ------------------------------------------------------------
   // Wake-up length counter
   // ------------------------------------------------------------
   int wake_cnt_r;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   // Counted here because a long repetition would slow the tools down
   always_ff @(posedge REF_CLK) begin
      if (RST || !wake_tx) begin
         wake_cnt_r <= 0;
      end else begin
         wake_cnt_r <= wake_cnt_r + 1;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_start_master: assert property (start_p |-> master)
      else $error("start pulse in slave mode");
   a_stop_slave: assert property (stop_p |-> !master)
      else $error("stop pulse in master mode");
   a_ack_slave: assert property (ack_p |-> !master)
      else $error("ack pulse in master mode");
   a_start_single: assert property (start_p |=> !start_p)
      else $error("start pulse longer than one cycle");
   a_stop_single: assert property (stop_p |=> !stop_p)
      else $error("stop pulse longer than one cycle");
   a_wake_single: assert property (wake_p |=> !wake_p)
      else $error("wake request pulse longer than one cycle");
   a_wake_cause: assert property ($rose(wake_tx) |-> ($past(wake_p) || $past(wake_p, 2)))
      else $error("wake-up driven without a request");
   a_wake_len: assert property ($fell(wake_tx) |-> wake_cnt_r == WAKE_CYC)
      else $error("wake-up signal of wrong length");
   a_wake_bound: assert property (wake_tx |-> wake_cnt_r < WAKE_CYC)
      else $error("wake-up signal too long");
endmodule : lfcs_props

// [bench/tb.sv]
// Self-checking bench: lfcs_ctrl and lfcs_link joined by lfcs_if.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module tb;
   localparam int WAKE_N = 20;
   localparam int FRAME_N = 300;
   localparam int IDLE_N = 3000;
   localparam int E_BRK = 0, E_ID = 1, E_BYTE1 = 2, E_DONE = 3, E_BIT = 7, E_WAKE = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   lfcs_pkg::lfcs_byte_t rdata;
   logic bus_rx = 1'b1;
   logic [1:0] id_hi = 2'b00;
   logic [8:0] ev = 9'h000;
   logic tx_start, tx_dir, tx_enh, wake_drv;
   logic [3:0] tx_len;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_start = 0;
   logic [7:0] regs [6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0F, 8'h0C};
   int eidx [3] = '{4, 5, 6};
   logic [7:0] ebit [3] = '{8'h10, 8'h08, 8'h02};
   lfcs_if lnk();
   lfcs_ctrl #(.IDLE_CYC(IDLE_N)) u_lfcs_ctrl (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .LNK(lnk));
   lfcs_link #(.FRAME_CYC(FRAME_N), .WAKE_CYC(WAKE_N)) u_lfcs_link (.REF_CLK(clk), .RST(rst), .LNK(lnk),
      .BUS_RX(bus_rx), .EV_BREAK(ev[0]), .EV_ID(ev[1]), .EV_BYTE1(ev[2]), .EV_DONE(ev[3]), .EV_SYNC_ERR(ev[4]),
      .EV_PAR_ERR(ev[5]), .EV_CHK_ERR(ev[6]), .EV_BIT_ERR(ev[7]), .EV_WAKE_RX(ev[8]), .ID_HI(id_hi),
      .TX_START(tx_start), .TX_DIR(tx_dir), .TX_LEN(tx_len), .TX_ENH(tx_enh), .WAKE_DRV(wake_drv));
   lfcs_props #(.WAKE_CYC(WAKE_N)) u_lfcs_props (.REF_CLK(clk), .RST(rst), .start_p(lnk.start_p),
      .stop_p(lnk.stop_p), .ack_p(lnk.ack_p), .wake_p(lnk.wake_p), .master(lnk.master), .wake_tx(lnk.wake_tx));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tx_start === 1'b1) n_start <= n_start + 1;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk8(input lfcs_pkg::lfcs_byte_t got, input lfcs_pkg::lfcs_byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk1
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_cyc
   task automatic do_reset(input int n);
      rst <= 1'b1;
      wait_cyc(n);
      rst <= 1'b0;
   endtask : do_reset
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk8(rdata & m, e);
   endtask : rc
   // Extra edge lets the register effect land before the next access
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 9'h000;
      @(posedge clk);
   endtask : pulse
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      do_reset(8);
      foreach (regs[i]) rc(regs[i], 8'hFF, 8'h00);
      wreg(8'h0C, 8'hFF);
      rc(8'h0C, 8'hFF, 8'h00);
      $display("Test reset values done");
      for (int c = 0; c < 16; c++) begin
         wreg(8'h0B, {4'hF, c[3:0]});
         rc(8'h0B, 8'hFF, {4'h8, c[3:0]});
         chk8({4'h0, lnk.len}, (c <= 8) ? 8'(c) : (c == 15) ? 8'h02 : 8'h00);
      end
      chk1(lnk.enh, 1'b1);
      // Upper identifier bits pass the link register, then the length register
      for (int h = 0; h < 4; h++) begin
         id_hi <= h[1:0];
         wait_cyc(3);
         chk8({4'h0, lnk.len}, (h == 3) ? 8'h08 : (h == 2) ? 8'h04 : 8'h02);
      end
      id_hi <= 2'b00;
      wreg(8'h0B, 8'h03);
      rc(8'h0B, 8'hFF, 8'h03);
      chk1(lnk.enh, 1'b0);
      $display("Test message size done");
      wreg(8'h08, 8'h02);
      for (int k = 0; k < 10 && wake_drv !== 1'b1; k++) begin
         @(posedge clk);
      end
      chk1(wake_drv, 1'b1);
      if (wake_drv !== 1'b1) end_sim();
      rc(8'h09, 8'h02, 8'h02);
      rc(8'h08, 8'h02, 8'h00);
      wait_cyc(WAKE_N + 4);
      chk1(wake_drv, 1'b0);
      rc(8'h09, 8'h02, 8'h00);
      pulse(E_WAKE);
      rc(8'h09, 8'h0A, 8'h0A);
      pulse(E_BRK);
      pulse(E_DONE);
      rc(8'h09, 8'h02, 8'h00);
      $display("Test wake-up done");
      wreg(8'h0F, 8'h40);
      wreg(8'h08, 8'h0C);
      chk1(lnk.master, 1'b1);
      wreg(8'h08, 8'h21);
      rc(8'h08, 8'h21, 8'h21);
      chk1(lnk.dir, 1'b1);
      chk1(tx_dir, 1'b1);
      chk8({4'h0, tx_len}, 8'h03);
      chk1(tx_enh, 1'b0);
      chk1(n_start == 1, 1'b1);
      rc(8'h09, 8'h01, 8'h00);
      pulse(E_DONE);
      rc(8'h09, 8'h0D, 8'h09);
      rc(8'h08, 8'h01, 8'h00);
      wreg(8'h08, 8'h00);
      wait_cyc(2);
      chk1(lnk.dir, 1'b0);
      rc(8'h09, 8'h08, 8'h08);
      wreg(8'h08, 8'h08);
      rc(8'h09, 8'h09, 8'h01);
      rc(8'h08, 8'h08, 8'h00);
      bus_rx <= 1'b0;
      wait_cyc(6);
      rc(8'h09, 8'h80, 8'h80);
      bus_rx <= 1'b1;
      $display("Test master frame done");
      wreg(8'h08, 8'h01);
      pulse(E_BIT);
      rc(8'h0A, 8'hFF, 8'h01);
      rc(8'h09, 8'h04, 8'h04);
      rc(8'h08, 8'h01, 8'h00);
      wreg(8'h08, 8'h00);
      rc(8'h0A, 8'hFF, 8'h01);
      wreg(8'h08, 8'h04);
      rc(8'h0A, 8'hFF, 8'h00);
      rc(8'h09, 8'h04, 8'h00);
      wreg(8'h08, 8'h01);
      wait_cyc(FRAME_N + 10);
      rc(8'h0A, 8'h04, 8'h04);
      $display("Test master errors done");
      wreg(8'h0F, 8'h00);
      wreg(8'h08, 8'h0C);
      pulse(E_BRK);
      rc(8'h09, 8'h21, 8'h00);
      pulse(E_ID);
      rc(8'h09, 8'h18, 8'h18);
      wreg(8'h08, 8'h10);
      rc(8'h09, 8'h10, 8'h00);
      rc(8'h08, 8'h10, 8'h00);
      pulse(E_BYTE1);
      pulse(E_DONE);
      rc(8'h0A, 8'h04, 8'h00);
      rc(8'h09, 8'h01, 8'h01);
      pulse(E_BRK);
      pulse(E_ID);
      pulse(E_BYTE1);
      rc(8'h0A, 8'h04, 8'h04);
      rc(8'h09, 8'h0C, 8'h0C);
      pulse(E_DONE);
      wreg(8'h08, 8'h0C);
      pulse(E_BRK);
      pulse(E_ID);
      wreg(8'h08, 8'h10);
      pulse(E_BRK);
      rc(8'h09, 8'h20, 8'h20);
      pulse(E_DONE);
      pulse(E_BRK);
      rc(8'h09, 8'h20, 8'h00);
      pulse(E_ID);
      wreg(8'h08, 8'h80);
      rc(8'h09, 8'h30, 8'h20);
      rc(8'h08, 8'h80, 8'h00);
      pulse(E_ID);
      pulse(eidx[0]);
      rc(8'h09, 8'h10, 8'h00);
      rc(8'h0A, 8'hFF, 8'h00);
      pulse(E_BRK);
      pulse(E_ID);
      rc(8'h09, 8'h10, 8'h10);
      wreg(8'h08, 8'h10);
      for (int i = 0; i < 3; i++) begin
         wreg(8'h08, 8'h04);
         pulse(eidx[i]);
         rc(8'h0A, 8'hFF, ebit[i]);
      end
      pulse(E_DONE);
      $display("Test slave frames done");
      do_reset(2);
      wait_cyc(IDLE_N + 20);
      rc(8'h09, 8'h40, 8'h40);
      do_reset(2);
      wreg(8'h08, 8'h40);
      wait_cyc(IDLE_N + 20);
      rc(8'h09, 8'h40, 8'h00);
      $display("Test idle timeout done");
      end_sim();
   end
endmodule : tb
